/* core/vegen_core.sv */
// Contract
// - After delay, ramp to maximum over attack; zero attack and delay reach maximum at once.
// - On trigger, hold output for delay time; zero delay enters attack at once.
// - After attack peak, descend toward sustain level over the decay time.
// - Sustain level 99 skips decay; level stays at maximum.
// - Sustain stage falls to zero over sustain-decay; 99 holds, 0 drops at once.
// - On release by key or pedal, fall from present level over release time.
// - Normal mode: a new note mid-cycle does not restart the envelope.
// - Normal mode: note release goes straight to release from any stage.
// - Free-run mode: whole sequence runs despite early release.
// - Reset mode: every new note restarts the sequence.
// - Reset plus free-run: restart on note and complete cycle despite release.
// - Time tracking speeds high keys, slows low keys, two octaves per doubling, not attack; the code does not track delay either.
// - Pedal on, zero delay and attack, decay 0 or sustain 99: key-up enters sustain decay.
// - Pedal on: key-up under pedal during attack skips to release.
// - Pedal on: key-up under pedal in delay keeps output 0; free-run rests in sustain decay.
// - Pedal off: sustain pedal is ignored entirely.
// - Output scaled by initial level 00 to 99.
// - Output scaled by velocity per velocity modulation; 99 full, 0 none.
// - Output contributes only with non-zero depth or when routed as a mod source.
`timescale 1ns/100ps
`default_nettype none

module vegen_core
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic note_on,
  input wire logic note_off,
  input wire logic [6:0] key_num,
  input wire logic [6:0] velocity,
  input wire logic pedal_down,
  input wire logic [6:0] attack_time,
  input wire logic [6:0] decay_time,
  input wire logic [6:0] sustain_level,
  input wire logic [6:0] release_time,
  input wire logic [6:0] delay_time,
  input wire logic [6:0] sus_decay_time,
  input wire logic [1:0] trig_mode,
  input wire logic time_track_en,
  input wire logic pedal_resp_en,
  input wire logic [6:0] init_level,
  input wire logic [6:0] vel_mod,
  input wire logic [6:0] env_depth,
  input wire logic mod_routed,
  output logic [15:0] env_out,
  output logic env_active,
  output logic [2:0] env_stage
);

  // ==========================================
  // State
  typedef struct packed {
    vegen_pkg::vegen_state_type st;
    logic [15:0] level;
    logic [15:0] delay_cnt;
    logic [15:0] tick_cnt;
    logic key_held;
    logic pedal_hold;
    logic [6:0] key;
    logic [6:0] vel;
    logic [15:0] out;
    logic active;
  } vegen_regs_type;

  vegen_regs_type r_q;
  vegen_regs_type r_d;

  // ==========================================
  // Step selection
  logic [6:0] cur_time;
  logic cur_track;
  logic [15:0] step;
  logic [15:0] sus_target;
  logic [15:0] dly_step;
  logic tick;
  logic freerun;
  logic reset_mode;
  logic quick_env;
  logic [22:0] scaled;
  logic [13:0] gain;
  logic [6:0] vel_term;
  logic [6:0] vel_clamped;

  assign freerun = trig_mode[0];
  assign reset_mode = trig_mode[1];

  // ==========================================
  // Sample tick
  // The tick runs free and is not restarted by a strike, so a stage may start up
  // to one sample late; this keeps every voice on one common sample grid
  assign tick = (r_q.tick_cnt == 16'(vegen_pkg::TICK_CYCLES - 1));

  // ==========================================
  // Stage targets
  // Sustain 99 maps to full scale, so the decay bypass lands exactly on the peak
  assign sus_target = 16'((32'(sustain_level) * 32'(vegen_pkg::LEVEL_FULL))
    / 32'(vegen_pkg::PARAM_MAX));
  assign quick_env = (delay_time == vegen_pkg::PARAM_ZERO)
    && (attack_time == vegen_pkg::PARAM_ZERO)
    && ((decay_time == vegen_pkg::PARAM_ZERO) || (sustain_level == vegen_pkg::PARAM_MAX));

  always_comb
  begin
    // Attack never follows the key; idle and delay read the delay time
    cur_track = time_track_en;
    case (r_q.st)
      vegen_pkg::ST_ATTACK:
      begin
        cur_time = attack_time;
        cur_track = 1'b0;
      end
      vegen_pkg::ST_DECAY: cur_time = decay_time;
      vegen_pkg::ST_SUSTAIN: cur_time = sus_decay_time;
      vegen_pkg::ST_RELEASE: cur_time = release_time;
      default:
      begin
        cur_time = delay_time;
        cur_track = 1'b0;
      end
    endcase
  end

  vegen_rate_lut u_lut
  (
    .time_val(cur_time),
    .track_en(cur_track),
    .key_num(r_q.key),
    .step(step)
  );

  assign dly_step = step;

  // ==========================================
  // Output gain
  // Velocity is clamped so a stray value above 99 cannot push the gain past unity
  always_comb
  begin
    vel_clamped = (r_q.vel > vegen_pkg::PARAM_MAX) ? vegen_pkg::PARAM_MAX : r_q.vel;
    vel_term = 7'((14'(vegen_pkg::PARAM_MAX - vel_mod) * 14'(vegen_pkg::PARAM_MAX)
      + 14'(vel_mod) * 14'(vel_clamped)) / 14'(vegen_pkg::PARAM_MAX));
    gain = 14'(init_level) * 14'(vel_term);
    scaled = 23'((39'(r_q.level) * 39'(gain))
      / 39'(14'(vegen_pkg::PARAM_MAX) * 14'(vegen_pkg::PARAM_MAX)));
  end

  // ==========================================
  // Next state
  always_comb
  begin
    logic key_up;
    logic sustained;
    logic release_req;
    key_up = 1'b0;
    sustained = 1'b0;
    release_req = 1'b0;
    r_d = r_q;
    r_d.tick_cnt = tick ? 16'h0000 : r_q.tick_cnt + 16'h0001;

    // A strike wins over a key-up in the same cycle
    if (note_on)
    begin
      r_d.key_held = 1'b1;
      r_d.pedal_hold = 1'b0;
      r_d.key = key_num;
      r_d.vel = velocity;
      // Normal and free-run keep the running cycle; only an idle or releasing envelope starts
      if (reset_mode || (r_q.st == vegen_pkg::ST_IDLE) || (r_q.st == vegen_pkg::ST_RELEASE))
      begin
        r_d.st = vegen_pkg::ST_DELAY;
        r_d.delay_cnt = 16'h0000;
        if (reset_mode)
          r_d.level = 16'h0000;
      end
    end
    else if (note_off && r_q.key_held)
    begin
      r_d.key_held = 1'b0;
      key_up = 1'b1;
      sustained = pedal_resp_en && pedal_down;
    end
    // Pedal let go after a sustained key-up counts as the release
    if (r_q.pedal_hold && !pedal_down && !note_on)
    begin
      r_d.pedal_hold = 1'b0;
      release_req = 1'b1;
    end

    // Pedal-held key-up: the quick case keeps sounding, a cut attack releases, a cut delay stays silent
    if (key_up)
    begin
      if (sustained)
      begin
        r_d.pedal_hold = 1'b1;
        if (quick_env && !freerun && r_q.st != vegen_pkg::ST_RELEASE)
          r_d.st = vegen_pkg::ST_SUSTAIN;
        else if (r_q.st == vegen_pkg::ST_ATTACK && !freerun)
          r_d.st = vegen_pkg::ST_RELEASE;
        else if (r_q.st == vegen_pkg::ST_DELAY && !freerun)
        begin
          r_d.st = vegen_pkg::ST_IDLE;
          r_d.level = 16'h0000;
        end
      end
      else if (!freerun)
        release_req = 1'b1;
    end
    if (release_req && !freerun && r_q.st != vegen_pkg::ST_IDLE)
      r_d.st = vegen_pkg::ST_RELEASE;

    // One level step per sample tick
    if (tick && (r_d.st == r_q.st))
    begin
      case (r_q.st)
        vegen_pkg::ST_DELAY:
        begin
          // Delay accumulates table steps and ends on wrap, so it scales like the other stages
          if (delay_time == vegen_pkg::PARAM_ZERO || (r_q.delay_cnt + dly_step < r_q.delay_cnt))
          begin
            r_d.st = vegen_pkg::ST_ATTACK;
            if (attack_time == vegen_pkg::PARAM_ZERO)
            begin
              r_d.level = vegen_pkg::LEVEL_FULL;
              r_d.st = (sustain_level == vegen_pkg::PARAM_MAX) ? vegen_pkg::ST_SUSTAIN
                : vegen_pkg::ST_DECAY;
            end
          end
          else
            r_d.delay_cnt = r_q.delay_cnt + dly_step;
        end
        vegen_pkg::ST_ATTACK:
        begin
          if (vegen_pkg::LEVEL_FULL - r_q.level <= step)
          begin
            r_d.level = vegen_pkg::LEVEL_FULL;
            r_d.st = (sustain_level == vegen_pkg::PARAM_MAX) ? vegen_pkg::ST_SUSTAIN
              : vegen_pkg::ST_DECAY;
          end
          else
            r_d.level = r_q.level + step;
        end
        vegen_pkg::ST_DECAY:
        begin
          if (r_q.level <= sus_target || r_q.level - sus_target <= step)
          begin
            r_d.level = sus_target;
            r_d.st = vegen_pkg::ST_SUSTAIN;
          end
          else
            r_d.level = r_q.level - step;
        end
        vegen_pkg::ST_SUSTAIN:
        begin
          if (sus_decay_time == vegen_pkg::PARAM_MAX)
            r_d.level = r_q.level;
          else if (sus_decay_time == vegen_pkg::PARAM_ZERO || r_q.level <= step)
            r_d.level = 16'h0000;
          else
            r_d.level = r_q.level - step;
          // Free-run ends once the key is gone and sustain decay has run out
          if (freerun && !r_q.key_held && !r_q.pedal_hold && r_d.level == 16'h0000)
            r_d.st = vegen_pkg::ST_IDLE;
        end
        vegen_pkg::ST_RELEASE:
        begin
          if (r_q.level <= step)
          begin
            r_d.level = 16'h0000;
            r_d.st = vegen_pkg::ST_IDLE;
          end
          else
            r_d.level = r_q.level - step;
        end
        default:
          r_d.level = 16'h0000;
      endcase
    end

    if ((env_depth != vegen_pkg::PARAM_ZERO) || mod_routed)
      r_d.out = scaled[15:0];
    else
      r_d.out = 16'h0000;
    // Registered so env_active lines up with env_stage and never glitches
    r_d.active = (r_d.st != vegen_pkg::ST_IDLE);
  end

  // ==========================================
  // Registers
  // Clock enable low freezes every field, the tick counter included
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      r_q <= '{st: vegen_pkg::ST_IDLE, default: '0};
    else if (clk_en)
      r_q <= r_d;
  end

  assign env_out = r_q.out;
  assign env_active = r_q.active;
  assign env_stage = r_q.st;

endmodule
`default_nettype wire

/* core/vegen_pkg.sv */
package vegen_pkg;

  // ==========================================
  // Parameter ranges
  localparam logic [6:0] PARAM_MAX = 7'h63;
  localparam logic [6:0] PARAM_ZERO = 7'h00;
  localparam int LEVEL_W = 16;
  localparam logic [15:0] LEVEL_FULL = 16'hffff;

  // ==========================================
  // Key tracking: rate doubles over two octaves around the centre key
  localparam logic [6:0] KEY_CENTER = 7'h3c;
  localparam logic [6:0] KEY_SPAN = 7'h18;
  localparam logic [6:0] KEY_HALF = 7'h0c;

  // ==========================================
  // Sample tick: 40 MHz core clock, nominal 48 kHz sample rate
  localparam int CLK_HZ = 40000000;
  localparam int SAMPLE_HZ = 48000;
  localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;

  // ==========================================
  // Trigger modes: bit 0 is free-run, bit 1 is reset
  typedef enum logic [1:0] {
    TRIG_NORMAL = 2'b00,
    TRIG_FREERUN = 2'b01,
    TRIG_RESET = 2'b10,
    TRIG_RESET_FREERUN = 2'b11
  } vegen_trig_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_ATTACK = 3'b010,
    ST_DECAY = 3'b011,
    ST_SUSTAIN = 3'b100,
    ST_RELEASE = 3'b101
  } vegen_state_type;

endpackage

/* core/vegen_rate_lut.sv */
`timescale 1ns/100ps
`default_nettype none

// Maps a 00-99 time value and a key to a per-sample level step.
// Small values give large steps; 0 gives a full-scale jump unless tracking is on and the key is below the centre.
module vegen_rate_lut
(
  input wire logic [6:0] time_val,
  input wire logic track_en,
  input wire logic [6:0] key_num,
  output logic [15:0] step
);

  logic [15:0] base;
  logic [6:0] inv;
  logic [16:0] tracked;
  logic [16:0] frac;

  always_comb
  begin
    // Exponential-ish curve: mantissa and shift from the inverted time
    inv = vegen_pkg::PARAM_MAX - time_val;
    if (time_val == vegen_pkg::PARAM_ZERO)
      base = vegen_pkg::LEVEL_FULL;
    else
      // Mantissa runs 16 to 31 so one octave of steps joins the next without a dip
      base = 16'({11'h000, 1'b1, inv[3:0]} << inv[6:4]);
    frac = 17'h00000;
    tracked = {1'b0, base};
    if (track_en)
    begin
      // Linear approximation of 2^(octave/2) across +-two octaves
      if (key_num >= vegen_pkg::KEY_CENTER)
      begin
        if (key_num - vegen_pkg::KEY_CENTER >= vegen_pkg::KEY_SPAN)
          tracked = {base, 1'b0};
        else
          tracked = 17'(base) + 17'((32'(base) * 32'(key_num - vegen_pkg::KEY_CENTER))
                    / 32'(vegen_pkg::KEY_SPAN));
      end
      else
      begin
        frac = 17'((32'(base) * 32'(vegen_pkg::KEY_CENTER - key_num))
               / 32'({vegen_pkg::KEY_SPAN, 1'b0}));
        if (vegen_pkg::KEY_CENTER - key_num >= vegen_pkg::KEY_SPAN)
          tracked = {2'b00, base[15:1]};
        else
          tracked = 17'(base) - frac;
      end
    end
    if (tracked[16])
      step = vegen_pkg::LEVEL_FULL;
    else if (tracked[15:0] == 16'h0000)
      step = 16'h0001;
    else
      step = tracked[15:0];
  end

endmodule
`default_nettype wire

/* sim/vegen_note_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Keyboard side: one-cycle key pulses, pedal as a level
module vegen_note_ctrl
(
  input wire logic core_clk,
  output logic note_on,
  output logic note_off,
  output logic [6:0] key_num,
  output logic [6:0] velocity,
  output logic pedal_down
);
  initial
  begin
    note_on = 1'b0;
    note_off = 1'b0;
    key_num = 7'h3c;
    velocity = 7'h40;
    pedal_down = 1'b0;
  end

  task automatic strike(input logic [6:0] k, input logic [6:0] v);
    @(posedge core_clk);
    #1;
    key_num = k;
    velocity = v;
    note_on = 1'b1;
    @(posedge core_clk);
    #1;
    note_on = 1'b0;
  endtask

  task automatic lift();
    @(posedge core_clk);
    #1;
    note_off = 1'b1;
    @(posedge core_clk);
    #1;
    note_off = 1'b0;
  endtask

  task automatic pedal(input logic p);
    @(posedge core_clk);
    #1;
    pedal_down = p;
  endtask
endmodule

`default_nettype wire

/* sim/vegen_core_sva.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Stage sequencing, reset and output gating checks
module vegen_core_sva
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic note_on,
  input wire logic note_off,
  input wire logic [6:0] attack_time,
  input wire logic [6:0] sustain_level,
  input wire logic [6:0] delay_time,
  input wire logic [1:0] trig_mode,
  input wire logic pedal_resp_en,
  input wire logic [6:0] env_depth,
  input wire logic mod_routed,
  input wire logic [15:0] env_out,
  input wire logic [2:0] env_stage
);
  property p_clear;
    @(posedge core_clk) rst |-> env_out == 16'h0000 && env_stage == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("level not clear in reset");
  property p_start;
    @(posedge core_clk) disable iff (rst)
    clk_en && note_on && env_stage == vegen_pkg::ST_IDLE |=> env_stage == vegen_pkg::ST_DELAY;
  endproperty
  a_start: assert property (p_start) else $error("strike did not start delay");
  property p_retrig;
    @(posedge core_clk) disable iff (rst)
    clk_en && note_on && trig_mode[1] |=> env_stage == vegen_pkg::ST_DELAY;
  endproperty
  a_retrig: assert property (p_retrig) else $error("no restart on strike");
  property p_keep;
    @(posedge core_clk) disable iff (rst)
    note_on && !trig_mode[1] && env_stage inside {[3'h2:3'h4]}
      |=> env_stage != vegen_pkg::ST_DELAY;
  endproperty
  a_keep: assert property (p_keep) else $error("cycle restarted");
  property p_rel;
    @(posedge core_clk) disable iff (rst)
    clk_en && note_off && !note_on && trig_mode == 2'b00 && !pedal_resp_en
      && env_stage inside {[3'h1:3'h4]} |=> env_stage == vegen_pkg::ST_RELEASE;
  endproperty
  a_rel: assert property (p_rel) else $error("key up did not release");
  property p_free;
    @(posedge core_clk) disable iff (rst)
    note_off && !note_on && trig_mode[0] && env_stage inside {[3'h1:3'h4]}
      |=> env_stage != vegen_pkg::ST_RELEASE;
  endproperty
  a_free: assert property (p_free) else $error("free run cut short");
  property p_skip;
    @(posedge core_clk) disable iff (rst)
    sustain_level == 7'h63 && env_stage == vegen_pkg::ST_ATTACK
      |=> env_stage != vegen_pkg::ST_DECAY;
  endproperty
  a_skip: assert property (p_skip) else $error("decay not bypassed");
  property p_fast;
    @(posedge core_clk) disable iff (rst)
    env_stage == vegen_pkg::ST_DELAY && delay_time == 7'h00 && attack_time == 7'h00
      |-> ##[1:840] env_stage inside {[3'h3:3'h5]};
  endproperty
  a_fast: assert property (p_fast) else $error("peak not reached at once");
  property p_depth;
    @(posedge core_clk) disable iff (rst)
    env_depth == 7'h00 && !mod_routed && $past(env_depth) == 7'h00 && !$past(mod_routed)
      && $past(clk_en) |-> env_out == 16'h0000;
  endproperty
  a_depth: assert property (p_depth) else $error("output without depth");
endmodule

bind vegen_core vegen_core_sva i_vegen_core_sva (.core_clk, .rst, .clk_en, .note_on, .note_off,
  .attack_time, .sustain_level, .delay_time, .trig_mode, .pedal_resp_en, .env_depth,
  .mod_routed, .env_out, .env_stage);

`default_nettype wire

/* sim/vegen_core_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module vegen_core_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic clk_en = 1'b1;
  logic [6:0] attack_time = 7'h00;
  logic [6:0] decay_time = 7'h00;
  logic [6:0] sustain_level = 7'h63;
  logic [6:0] release_time = 7'h00;
  logic [6:0] delay_time = 7'h00;
  logic [6:0] sus_decay_time = 7'h63;
  logic [1:0] trig_mode = 2'b00;
  logic time_track_en = 1'b0;
  logic pedal_resp_en = 1'b0;
  logic [6:0] init_level = 7'h63;
  logic [6:0] vel_mod = 7'h00;
  logic [6:0] env_depth = 7'h01;
  logic mod_routed = 1'b0;
  logic note_on, note_off, pedal_down, env_active;
  logic [6:0] key_num, velocity;
  logic [15:0] env_out;
  logic [2:0] env_stage;
  int fails = 0;
  int n_compared = 0;
  int il, vm, vl;
  int n_dec [2];
  logic [15:0] frz;

  always #12.5 core_clk = ~core_clk;

  vegen_note_ctrl i_vegen_note_ctrl (.core_clk, .note_on, .note_off, .key_num, .velocity,
    .pedal_down);
  vegen_core i_vegen_core (.core_clk, .rst, .clk_en, .note_on, .note_off, .key_num,
    .velocity, .pedal_down, .attack_time, .decay_time, .sustain_level, .release_time,
    .delay_time, .sus_decay_time, .trig_mode, .time_track_en, .pedal_resp_en, .init_level,
    .vel_mod, .env_depth, .mod_routed, .env_out, .env_active, .env_stage);

  // ==========================================
  // Expectations and comparison
  function automatic logic [15:0] scale(input int lv, input int m, input int v);
    int vt;
    vt = ((99 - m) * 99 + m * v) / 99;
    return 16'(65535 * lv * vt / 9801);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bounded so a stuck stage shows as one mismatch, not a hang
  task automatic wait_stage(input logic [2:0] s);
    int n;
    n = 0;
    while (env_stage !== s && n < 3000)
    begin
      cyc(1);
      n++;
    end
    check(16'(env_stage), 16'(s));
  endtask

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #(25 * 90000);
    fails++;
    print_verdict();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h117eab9e));
    // Raised after time zero so the asynchronous reset sees a real edge
    #1;
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      il = $urandom_range(99);
      vm = (i == 0) ? 99 : $urandom_range(99);
      vl = $urandom_range(99);
      init_level = 7'(il);
      vel_mod = 7'(vm);
      env_depth = (i == 3) ? 7'h00 : 7'($urandom_range(99, 1));
      mod_routed = (i == 2);
      time_track_en = 1'($urandom);
      i_vegen_note_ctrl.strike(7'($urandom_range(99)), 7'(vl));
      wait_stage(vegen_pkg::ST_SUSTAIN);
      check(16'(env_active), 16'h0001);
      cyc(2);
      check(env_out, (i == 3) ? 16'h0000 : scale(il, vm, vl));
      i_vegen_note_ctrl.lift();
      check(16'(env_stage), 16'(vegen_pkg::ST_RELEASE));
      wait_stage(vegen_pkg::ST_IDLE);
      cyc(2);
      check(env_out, 16'h0000);
      check(16'(env_active), 16'h0000);
    end
    env_depth = 7'h01;
    init_level = 7'h63;
    vel_mod = 7'h00;
    sustain_level = 7'h31;
    time_track_en = 1'b1;
    // Decay time measured on a high and a low key with tracking on
    for (int k = 0; k < 2; k++)
    begin
      i_vegen_note_ctrl.strike((k == 0) ? 7'h54 : 7'h24, 7'h40);
      wait_stage(vegen_pkg::ST_DECAY);
      n_dec[k] = 0;
      while (env_stage === vegen_pkg::ST_DECAY && n_dec[k] < 3000)
      begin
        cyc(1);
        n_dec[k]++;
      end
      check(16'(env_stage), 16'(vegen_pkg::ST_SUSTAIN));
      cyc(2);
      check(env_out, 16'(65535 * 49 / 99));
      i_vegen_note_ctrl.lift();
      wait_stage(vegen_pkg::ST_IDLE);
    end
    check(16'(n_dec[1] > n_dec[0]), 16'h0001);
    sustain_level = 7'h63;
    time_track_en = 1'b0;
    sus_decay_time = 7'h00;
    for (int m = 0; m < 4; m++)
    begin
      trig_mode = 2'(m);
      i_vegen_note_ctrl.strike(7'h30, 7'h50);
      wait_stage(vegen_pkg::ST_SUSTAIN);
      cyc(900);
      check(env_out, 16'h0000);
      i_vegen_note_ctrl.strike(7'h40, 7'h50);
      check(16'(env_stage == vegen_pkg::ST_DELAY), 16'(trig_mode[1]));
      wait_stage(vegen_pkg::ST_SUSTAIN);
      i_vegen_note_ctrl.lift();
      check(16'(env_stage == vegen_pkg::ST_RELEASE), 16'(!trig_mode[0]));
      wait_stage(vegen_pkg::ST_IDLE);
    end
    trig_mode = 2'b00;
    sus_decay_time = 7'h63;
    i_vegen_note_ctrl.pedal(1'b1);
    i_vegen_note_ctrl.strike(7'h3c, 7'h63);
    wait_stage(vegen_pkg::ST_SUSTAIN);
    i_vegen_note_ctrl.lift();
    check(16'(env_stage), 16'(vegen_pkg::ST_RELEASE));
    wait_stage(vegen_pkg::ST_IDLE);
    pedal_resp_en = 1'b1;
    i_vegen_note_ctrl.strike(7'h3c, 7'h63);
    wait_stage(vegen_pkg::ST_SUSTAIN);
    i_vegen_note_ctrl.lift();
    cyc(1);
    check(16'(env_stage), 16'(vegen_pkg::ST_SUSTAIN));
    i_vegen_note_ctrl.pedal(1'b0);
    wait_stage(vegen_pkg::ST_RELEASE);
    wait_stage(vegen_pkg::ST_IDLE);
    attack_time = 7'h63;
    i_vegen_note_ctrl.pedal(1'b1);
    i_vegen_note_ctrl.strike(7'h3c, 7'h63);
    wait_stage(vegen_pkg::ST_ATTACK);
    cyc(1700);
    frz = env_out;
    check(16'(frz > 16'h0000), 16'h0001);
    clk_en = 1'b0;
    cyc(900);
    check(env_out, frz);
    check(16'(env_stage), 16'(vegen_pkg::ST_ATTACK));
    clk_en = 1'b1;
    i_vegen_note_ctrl.lift();
    check(16'(env_stage), 16'(vegen_pkg::ST_RELEASE));
    wait_stage(vegen_pkg::ST_IDLE);
    print_verdict();
  end
endmodule

`default_nettype wire
